//--- dv/busy_station_model.sv
`timescale 1ns/100ps
module busy_station_model (
    input  wire logic       CLK,
    input  wire logic [1:0] OCCUPY,
    output logic      [1:0] BUSY
);
    // registered, so busy moves one edge after the other station acts
    always_ff @(posedge CLK) BUSY <= OCCUPY;
endmodule

//--- dv/shared_channel_key_arbiter_chk.sv
`timescale 1ns/100ps
`include "shared_channel_consts.svh"
module arb_chk (
    input wire logic       CLK,
    input wire logic       RST_N,
    input wire logic [1:0] INTERFACE_MODE_SETTING,
    input wire logic [1:0] SHARED_CHANNEL_ENABLE,
    input wire logic [1:0] SINGLE_CHANNEL_ASSIGNED,
    input wire logic [1:0] PAGES_PENDING,
    input wire logic [1:0] CHANNEL_BUSY_IN,
    input wire logic [1:0] CHANNEL_REQUEST_OUT,
    input wire logic [1:0] TRANSMITTER_KEY,
    input wire logic       REQUEST_INDICATOR
);
    wire logic on0 = INTERFACE_MODE_SETTING != `MODE_OTHER && SHARED_CHANNEL_ENABLE[0] && SINGLE_CHANNEL_ASSIGNED[0];
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    sequence s_pend0;
        $rose(PAGES_PENDING[0]) && on0 && !CHANNEL_REQUEST_OUT[0] && !TRANSMITTER_KEY[0] && !$past(TRANSMITTER_KEY[0]);
    endsequence
    sequence s_clr0; $rose(CHANNEL_REQUEST_OUT[0]) && !CHANNEL_BUSY_IN[0]; endsequence
    sequence s_clr1; $rose(CHANNEL_REQUEST_OUT[1]) && !CHANNEL_BUSY_IN[1]; endsequence
    AST_OFF: assert property (!on0 && !CHANNEL_REQUEST_OUT[0] |=> !CHANNEL_REQUEST_OUT[0])
        else $error("request while off");
    AST_REQ: assert property (s_pend0 |=> CHANNEL_REQUEST_OUT[0] && REQUEST_INDICATOR)
        else $error("no request");
    AST_BUSY: assert property ($rose(TRANSMITTER_KEY[0]) && on0 |-> !$past(CHANNEL_BUSY_IN[0]))
        else $error("key while busy");
    AST_DROP: assert property ($fell(TRANSMITTER_KEY[0]) && $past(CHANNEL_REQUEST_OUT[0]) |-> !CHANNEL_REQUEST_OUT[0])
        else $error("request kept");
    AST_LOSE: assert property ($rose(TRANSMITTER_KEY[0]) && $past(CHANNEL_REQUEST_OUT[0])
        && $past(CHANNEL_REQUEST_OUT[1]) && !TRANSMITTER_KEY[1]
        |-> !CHANNEL_REQUEST_OUT[1]) else $error("loser kept request");
    AST_PROMPT0: assert property (s_clr0 |=> TRANSMITTER_KEY[0]) else $error("late key");
    AST_PROMPT1: assert property (s_clr1 && !(CHANNEL_REQUEST_OUT[0] && !TRANSMITTER_KEY[0] && !CHANNEL_BUSY_IN[0])
        |=> TRANSMITTER_KEY[1]) else $error("late key");
endmodule
////////////////////////////////////////
bind shared_channel_key_arbiter arb_chk u_chk (.CLK, .RST_N, .INTERFACE_MODE_SETTING, .SHARED_CHANNEL_ENABLE,
    .SINGLE_CHANNEL_ASSIGNED, .PAGES_PENDING, .CHANNEL_BUSY_IN, .CHANNEL_REQUEST_OUT, .TRANSMITTER_KEY,
    .REQUEST_INDICATOR);

//--- dv/tb_shared_channel_key_arbiter.sv
`timescale 1ns/100ps
module tb_shared_channel_key_arbiter;
    logic       clk = 1'h0, rst_n = 1'h0, ind;
    logic [1:0] mode = 2'h0, en = 2'h3, sca = 2'h3, pend = 2'h0, done = 2'h0, occ = 2'h0, busy, req, key;
    int         n_errors = 0, num_checks = 0;
    always #5 clk = ~clk;
    busy_station_model bsm (.CLK(clk), .OCCUPY(occ), .BUSY(busy));
    shared_channel_key_arbiter dut (.CLK(clk), .RST_N(rst_n), .CLK_EN(1'h1), .INTERFACE_MODE_SETTING(mode),
        .SHARED_CHANNEL_ENABLE(en), .SINGLE_CHANNEL_ASSIGNED(sca), .PAGES_PENDING(pend), .SEND_DONE(done),
        .CHANNEL_BUSY_IN(busy), .CHANNEL_REQUEST_OUT(req), .TRANSMITTER_KEY(key), .REQUEST_INDICATOR(ind));
    ////////////////////////////////////////
    task automatic chk(logic [4:0] seen, logic [4:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR ind_req_key exp %h seen %h", exp, seen);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(negedge clk);
    endtask
    // done on an idle port is harmless, so both ports are closed at once
    task automatic fin(string s);
        pend = 2'h0;
        occ = 2'h0;
        done = 2'h3;
        cyc(1);
        chk({ind, req, key}, 5'h00);
        done = 2'h0;
        cyc(3);
        $display("test %s done", s);
    endtask
    task automatic t_prompt(int p);
        pend = 2'h1 << p;
        cyc(1);
        chk({ind, req, key}, {1'h1, pend, 2'h0});
        cyc(1);
        chk({ind, req, key}, {1'h1, pend, pend});
        fin("prompt");
    endtask
    task automatic t_busy;
        occ = 2'h1;
        pend = 2'h1;
        cyc(4);
        chk({ind, req, key}, 5'h14);
        occ = 2'h0;
        cyc(1);
        chk({ind, req, key}, 5'h14);
        cyc(1);
        chk({ind, req, key}, 5'h15);
        fin("busy");
    endtask
    task automatic t_both;
        occ = 2'h3;
        pend = 2'h3;
        cyc(4);
        chk({ind, req, key}, 5'h1c);
        occ = 2'h2;
        cyc(2);
        chk({ind, req, key}, 5'h15);
        fin("both");
    endtask
    task automatic t_off;
        for (int i = 0; i < 6; i++) begin
            mode = i[1:0];
            en = (i == 4) ? 2'h2 : 2'h3;
            sca = (i == 5) ? 2'h2 : 2'h3;
            pend = 2'h1;
            cyc(2);
            chk({ind, req, key}, (i < 3) ? 5'h15 : 5'h01);
            fin("mode");
        end
    endtask
    task complete_run;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        cyc(4);
        rst_n = 1'h1;
        t_prompt(0);
        t_prompt(1);
        t_busy;
        t_both;
        t_off;
        complete_run;
    end
endmodule

//--- logic/shared_channel_key_arbiter.sv
`timescale 1ns/100ps
`include "shared_channel_consts.svh"

// Behaviour
// - The handshake is used on a port only in pager, TNPP or master mode with that port's enable on.
// - Each of the two ports runs the handshake on its own, when it has exactly one channel assigned.
// - A port with pages queued raises its channel request and lights the request indicator.
// - While busy is active the key stays off; keying and sending start only once busy is inactive.
// - Dropping the key at the end of sending drops the channel request in the same cycle.
// - If both ports wait and one keys, the other port's request is dropped to free its channel.
module shared_channel_key_arbiter (
    input  wire logic                 CLK,
    input  wire logic                 RST_N,
    input  wire logic                 CLK_EN,
    input  wire logic [`MODE_W-1:0]   INTERFACE_MODE_SETTING,
    input  wire logic [1:0]           SHARED_CHANNEL_ENABLE,
    input  wire logic [1:0]           SINGLE_CHANNEL_ASSIGNED,
    input  wire logic [1:0]           PAGES_PENDING,
    input  wire logic [1:0]           SEND_DONE,
    input  wire logic [1:0]           CHANNEL_BUSY_IN,
    output logic      [1:0]           CHANNEL_REQUEST_OUT,
    output logic      [1:0]           TRANSMITTER_KEY,
    output logic                      REQUEST_INDICATOR
);

    ////////////////////////////////////////////////////////////////////////////
    logic       mode_ok;
    logic [1:0] handshake_on;
    logic [1:0] waiting;
    logic [1:0] want;
    logic [1:0] req_next;
    logic [1:0] req_q;
    logic [1:0] key_q;
    logic       ind_r;
    logic       ind_nxt;

    // the fourth mode setting leaves both lines alone, so busy never holds off the key there
    assign mode_ok = (INTERFACE_MODE_SETTING == `MODE_PAGER) ||
                     (INTERFACE_MODE_SETTING == `MODE_TNPP) ||
                     (INTERFACE_MODE_SETTING == `MODE_MASTER);

    // a port with several channels cannot tell which one the busy line speaks for
    assign handshake_on = {2{mode_ok}} & SHARED_CHANNEL_ENABLE & SINGLE_CHANNEL_ASSIGNED;

    ////////////////////////////////////////////////////////////////////////////
    // port 0 wins a tie: a fixed priority is cheap, and the losing port asks again
    // as soon as it is back in idle with pages still pending
    channel_port_fsm #(
        .WINS_TIE      (1'b1)
    ) u_port0 (
        .clk           (CLK),
        .rst_n         (RST_N),
        .clk_en        (CLK_EN),
        .handshake_on  (handshake_on[0]),
        .pages_pending (PAGES_PENDING[0]),
        .send_done     (SEND_DONE[0]),
        .busy          (CHANNEL_BUSY_IN[0]),
        .other_waiting (waiting[1]),
        .other_want    (want[1]),
        .waiting       (waiting[0]),
        .want          (want[0]),
        .req_next      (req_next[0]),
        .req           (req_q[0]),
        .key           (key_q[0])
    );

    channel_port_fsm #(
        .WINS_TIE      (1'b0)
    ) u_port1 (
        .clk           (CLK),
        .rst_n         (RST_N),
        .clk_en        (CLK_EN),
        .handshake_on  (handshake_on[1]),
        .pages_pending (PAGES_PENDING[1]),
        .send_done     (SEND_DONE[1]),
        .busy          (CHANNEL_BUSY_IN[1]),
        .other_waiting (waiting[0]),
        .other_want    (want[0]),
        .waiting       (waiting[1]),
        .want          (want[1]),
        .req_next      (req_next[1]),
        .req           (req_q[1]),
        .key           (key_q[1])
    );

    ////////////////////////////////////////////////////////////////////////////
    // indicator follows the registered requests, so it is built from their next values
    always_comb begin
        ind_nxt = |req_next;
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ind_r <= 1'b0;
        end else if (CLK_EN) begin
            ind_r <= ind_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // all three outputs come straight from flip-flops
    assign CHANNEL_REQUEST_OUT = req_q;
    assign TRANSMITTER_KEY     = key_q;
    assign REQUEST_INDICATOR   = ind_r;

endmodule

////////////////////////////////////////////////////////////////////////////////
// one exciter port: request, wait for a free channel, key, release
module channel_port_fsm #(
    parameter bit WINS_TIE = 1'b0
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic clk_en,
    input  wire logic handshake_on,
    input  wire logic pages_pending,
    input  wire logic send_done,
    input  wire logic busy,
    input  wire logic other_waiting,
    input  wire logic other_want,
    output logic      waiting,
    output logic      want,
    output logic      req_next,
    output logic      req,
    output logic      key
);

    ////////////////////////////////////////////////////////////////////////////
    shared_channel_pkg::port_state_t state_r;
    shared_channel_pkg::port_state_t state_nxt;
    logic                            req_r;
    logic                            req_nxt;
    logic                            key_r;
    logic                            key_nxt;
    logic                            lose;

    // only a port that is actually holding its request out can take part in contention
    assign waiting = (state_r == shared_channel_pkg::ST_WAIT) && req_r;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_nxt = state_r;
        req_nxt   = req_r;
        key_nxt   = key_r;
        want      = 1'b0;
        case (state_r)
            shared_channel_pkg::ST_IDLE: begin
                if (pages_pending) begin
                    req_nxt   = handshake_on;
                    state_nxt = shared_channel_pkg::ST_WAIT;
                end
            end
            shared_channel_pkg::ST_WAIT: begin
                // busy only gates keying when the handshake is in use on this port
                if (!handshake_on || !busy) begin
                    want      = 1'b1;
                    key_nxt   = 1'b1;
                    req_nxt   = handshake_on;
                    state_nxt = shared_channel_pkg::ST_KEY;
                end else if (!pages_pending) begin
                    req_nxt   = 1'b0;
                    state_nxt = shared_channel_pkg::ST_IDLE;
                end
            end
            shared_channel_pkg::ST_KEY: begin
                if (send_done) begin
                    key_nxt   = 1'b0;
                    req_nxt   = 1'b0;
                    state_nxt = shared_channel_pkg::ST_DONE;
                end
            end
            shared_channel_pkg::ST_DONE: begin
                // one idle cycle so a new request is a fresh edge on the line
                state_nxt = shared_channel_pkg::ST_IDLE;
            end
            default: begin
                key_nxt   = 1'b0;
                req_nxt   = 1'b0;
                state_nxt = shared_channel_pkg::ST_IDLE;
            end
        endcase

        // the other port keys while both wait: give this channel back to the other stations
        lose = waiting && other_waiting && other_want && (!want || !WINS_TIE);
        if (lose) begin
            key_nxt   = 1'b0;
            req_nxt   = 1'b0;
            state_nxt = shared_channel_pkg::ST_IDLE;
        end
        req_next = req_nxt;
    end

    ////////////////////////////////////////////////////////////////////////////
    // clock enable low freezes the port, requests and key included
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= shared_channel_pkg::ST_IDLE;
            req_r   <= 1'b0;
            key_r   <= 1'b0;
        end else if (clk_en) begin
            state_r <= state_nxt;
            req_r   <= req_nxt;
            key_r   <= key_nxt;
        end
    end

    assign req = req_r;
    assign key = key_r;

endmodule

//--- pkg/shared_channel_consts.svh
`ifndef SHARED_CHANNEL_CONSTS_SVH
`define SHARED_CHANNEL_CONSTS_SVH

// interface mode setting encodings
`define MODE_W        2
`define MODE_PAGER    2'h0
`define MODE_TNPP     2'h1
`define MODE_MASTER   2'h2
`define MODE_OTHER    2'h3

`define NUM_PORTS     2

`endif

//--- pkg/shared_channel_pkg.sv
package shared_channel_pkg;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_WAIT = 4'h2,
        ST_KEY  = 4'h4,
        ST_DONE = 4'h8
    } port_state_t;
endpackage
